// ---- uerp_checker.sv ----
module uerp_checker (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic [7:0] report,
    input wire logic posted,
    input wire logic [1:0] power_state_bits,
    input wire logic wake_event_enable,
    input wire logic wake_request_in,
    input wire logic i_advanced_error_reporting_enable,
    input wire logic [2:0] i_msg_enable,
    input wire logic o_send_cpl,
    input wire logic o_cpl_status,
    input wire logic o_send_msg,
    input wire logic [1:0] o_msg_kind,
    input wire logic o_wake_req
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    sequence s_wake;
        wake_request_in ##1 o_wake_req;
    endsequence
    property p_one_hot;
        report != 8'h00 |-> $onehot(report);
    endproperty
    property p_power;
        report != 8'h00 |-> $past(power_state_bits) == 2'h0;
    endproperty
    property p_ur_cpl;
        report[0] && !posted |=> o_send_cpl && o_cpl_status == uerp_pkg::CPL_STATUS_UR;
    endproperty
    property p_ca_cpl;
        report[1] |=> o_send_cpl && o_cpl_status == uerp_pkg::CPL_STATUS_CA;
    endproperty
    property p_no_cpl;
        report != 8'h00 && !report[1] && !(report[0] && !posted) |=> !o_send_cpl;
    endproperty
    property p_cor_msg;
        (report[6] || report[7]) && i_msg_enable[0] |=> o_send_msg && o_msg_kind == 2'h0;
    endproperty
    property p_nf_msg;
        (report[5] || report[0] && posted) && i_msg_enable[1] && !i_advanced_error_reporting_enable
            |=> o_send_msg && o_msg_kind == 2'h1;
    endproperty
    property p_wake;
        wake_request_in |-> (wake_event_enable && power_state_bits != 2'h0) ##0 s_wake;
    endproperty
    a_one_hot: assert property (p_one_hot) else $error("two reports in one cycle");
    a_power: assert property (p_power) else $error("report outside fully-on");
    a_ur_cpl: assert property (p_ur_cpl) else $error("missing UR completion");
    a_ca_cpl: assert property (p_ca_cpl) else $error("missing CA completion");
    a_no_cpl: assert property (p_no_cpl) else $error("stray completion");
    a_cor_msg: assert property (p_cor_msg) else $error("missing correctable message");
    a_nf_msg: assert property (p_nf_msg) else $error("missing non-fatal message");
    a_wake: assert property (p_wake) else $error("wake pulse misplaced");
endmodule : uerp_checker

// ---- uerp_core_end.sv ----
// Overview of operation
// - User raises at most one report per cycle.
// - Several errors in one packet: report one.
// - Posted qualifier picks completion or message for UR; CA always gets a completion.
// - Report only while power state is fully-on.
// - Non-fully-on with wake enable: pulse wake, wait.
// - Non-fully-on without wake enable: just wait.
// - Non-posted UR: UR completion, optional correctable message.
// - Posted UR: non-fatal, or severity-selected when advanced.
// - Non-posted CA: CA completion, non-fatal or correctable.
// - Posted CA: CA completion, non-fatal or severity-selected.
// - Recoverable timeout, unexpected, atomic: advisory or correctable.
// - Unrecoverable timeout: non-fatal or severity-selected.
// - ECRC: non-fatal or severity-selected.
// - Correctable kinds send correctable message when its enable bit is set.
module uerp_core_end (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    uerp_if.core_mp link,
    input wire logic [1:0] i_power_state,
    input wire logic i_wake_event_enable,
    input wire logic i_advanced_error_reporting_enable,
    input wire logic [7:0] i_fatal_severity,
    input wire logic [2:0] i_msg_enable,
    output logic o_send_cpl,
    output logic o_cpl_status,
    output logic o_send_msg,
    output logic [1:0] o_msg_kind,
    output logic o_wake_req,
    output logic o_misuse
);
    logic send_cpl_r;
    logic send_cpl_nxt;
    logic cpl_status_r;
    logic cpl_status_nxt;
    logic send_msg_r;
    logic send_msg_nxt;
    logic [1:0] msg_kind_r;
    logic [1:0] msg_kind_nxt;
    logic wake_req_r;
    logic wake_req_nxt;
    logic misuse_r;
    logic misuse_nxt;
    logic [1:0] power_r;
    logic [1:0] power_nxt;
    logic wake_en_r;
    logic wake_en_nxt;

    assign link.power_state_bits = power_r;
    assign link.wake_event_enable = wake_en_r;
    assign o_send_cpl = send_cpl_r;
    assign o_cpl_status = cpl_status_r;
    assign o_send_msg = send_msg_r;
    assign o_msg_kind = msg_kind_r;
    assign o_wake_req = wake_req_r;
    assign o_misuse = misuse_r;

    // Uncorrectable kind: non-fatal unless advanced reporting marks it fatal.
    function automatic logic [1:0] uncor_kind(input logic adv, input logic fatal);
        uncor_kind = (adv && fatal) ? uerp_pkg::MSG_FATAL : uerp_pkg::MSG_NONFATAL;
    endfunction : uncor_kind

    always_comb
    begin
        logic [7:0] rep;
        logic want_msg;
        logic multi;
        logic [1:0] kind;
        rep = link.report;
        want_msg = 1'b0;
        kind = uerp_pkg::MSG_COR;
        send_cpl_nxt = 1'b0;
        cpl_status_nxt = cpl_status_r;
        power_nxt = i_power_state;
        wake_en_nxt = i_wake_event_enable;
        wake_req_nxt = link.wake_request_in;
        // Two lines at once has no defined meaning, so nothing is sent.
        multi = (rep & (rep - 8'h01)) != 8'h00;
        misuse_nxt = (rep != uerp_pkg::REP_NONE)
            && (multi || power_r != uerp_pkg::PWR_FULLY_ON);
        if (!multi)
        begin
            if (rep[uerp_pkg::REP_UR])
            begin
                if (!link.posted)
                begin
                    send_cpl_nxt = 1'b1;
                    cpl_status_nxt = uerp_pkg::CPL_STATUS_UR;
                    want_msg = i_advanced_error_reporting_enable;
                    kind = uerp_pkg::MSG_COR;
                end
                else
                begin
                    want_msg = 1'b1;
                    kind = uncor_kind(i_advanced_error_reporting_enable,
                        i_fatal_severity[uerp_pkg::REP_UR]);
                end
            end
            if (rep[uerp_pkg::REP_CPL_ABORT])
            begin
                send_cpl_nxt = 1'b1;
                cpl_status_nxt = uerp_pkg::CPL_STATUS_CA;
                want_msg = 1'b1;
                if (!link.posted)
                begin
                    kind = i_advanced_error_reporting_enable ? uerp_pkg::MSG_COR
                        : uerp_pkg::MSG_NONFATAL;
                end
                else
                begin
                    kind = uncor_kind(i_advanced_error_reporting_enable,
                        i_fatal_severity[uerp_pkg::REP_CPL_ABORT]);
                end
            end
            if (rep[uerp_pkg::REP_CPL_TIMEOUT])
            begin
                if (link.no_recovery)
                begin
                    want_msg = 1'b1;
                    kind = uncor_kind(i_advanced_error_reporting_enable,
                        i_fatal_severity[uerp_pkg::REP_CPL_TIMEOUT]);
                end
                else
                begin
                    want_msg = i_advanced_error_reporting_enable;
                    kind = uerp_pkg::MSG_COR;
                end
            end
            if (rep[uerp_pkg::REP_CPL_UNEXPECT] || rep[uerp_pkg::REP_ATOMIC_BLOCKED])
            begin
                // Advisory non-fatal unless advanced: only status would change.
                want_msg = i_advanced_error_reporting_enable;
                kind = uerp_pkg::MSG_COR;
            end
            if (rep[uerp_pkg::REP_ECRC])
            begin
                want_msg = 1'b1;
                kind = uncor_kind(i_advanced_error_reporting_enable,
                    i_fatal_severity[uerp_pkg::REP_ECRC]);
            end
            if (rep[uerp_pkg::REP_COR] || rep[uerp_pkg::REP_INTERNAL_COR])
            begin
                want_msg = 1'b1;
                kind = uerp_pkg::MSG_COR;
            end
        end
        send_msg_nxt = want_msg && i_msg_enable[kind];
        msg_kind_nxt = want_msg ? kind : msg_kind_r;
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            send_cpl_r <= 1'b0;
            cpl_status_r <= uerp_pkg::CPL_STATUS_UR;
            send_msg_r <= 1'b0;
            msg_kind_r <= uerp_pkg::MSG_COR;
            wake_req_r <= 1'b0;
            misuse_r <= 1'b0;
            power_r <= uerp_pkg::PWR_RESET;
            wake_en_r <= 1'b0;
        end
        else
        begin
            send_cpl_r <= send_cpl_nxt;
            cpl_status_r <= cpl_status_nxt;
            send_msg_r <= send_msg_nxt;
            msg_kind_r <= msg_kind_nxt;
            wake_req_r <= wake_req_nxt;
            misuse_r <= misuse_nxt;
            power_r <= power_nxt;
            wake_en_r <= wake_en_nxt;
        end
    end
endmodule : uerp_core_end

// ---- uerp_if.sv ----
interface uerp_if;
    logic [7:0] report;
    logic posted;
    logic no_recovery;
    logic [1:0] power_state_bits;
    logic wake_event_enable;
    logic wake_request_in;

    modport core_mp (
        input report,
        input posted,
        input no_recovery,
        input wake_request_in,
        output power_state_bits,
        output wake_event_enable
    );

    modport user_mp (
        output report,
        output posted,
        output no_recovery,
        output wake_request_in,
        input power_state_bits,
        input wake_event_enable
    );
endinterface : uerp_if

// ---- uerp_pkg.sv ----
package uerp_pkg;
    // Bit positions of the error-report vector, one line per error kind.
    localparam int REP_W = 8;
    localparam int REP_UR = 0;
    localparam int REP_CPL_ABORT = 1;
    localparam int REP_CPL_TIMEOUT = 2;
    localparam int REP_CPL_UNEXPECT = 3;
    localparam int REP_ATOMIC_BLOCKED = 4;
    localparam int REP_ECRC = 5;
    localparam int REP_COR = 6;
    localparam int REP_INTERNAL_COR = 7;
    localparam logic [REP_W-1:0] REP_NONE = 8'h00;

    localparam int PWR_W = 2;
    localparam logic [PWR_W-1:0] PWR_FULLY_ON = 2'h0;
    localparam logic [PWR_W-1:0] PWR_RESET = 2'h0;

    // Message kinds; also the index into the message enable vector.
    localparam int MSG_W = 2;
    localparam int MSG_KINDS = 3;
    localparam logic [MSG_W-1:0] MSG_COR = 2'h0;
    localparam logic [MSG_W-1:0] MSG_NONFATAL = 2'h1;
    localparam logic [MSG_W-1:0] MSG_FATAL = 2'h2;

    localparam logic CPL_STATUS_UR = 1'h0;
    localparam logic CPL_STATUS_CA = 1'h1;

    typedef enum logic [1:0] {
        UERP_ST_IDLE = 2'h1,
        UERP_ST_WAIT = 2'h2
    } uerp_state_t;
endpackage : uerp_pkg

// ---- uerp_user_end.sv ----
module uerp_user_end (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    uerp_if.user_mp link,
    input wire logic i_err_valid,
    input wire logic [7:0] i_err_found,
    input wire logic i_posted,
    input wire logic i_no_recovery,
    output logic o_ready,
    output logic o_waiting,
    output logic o_sent
);
    uerp_pkg::uerp_state_t state_r;
    uerp_pkg::uerp_state_t state_nxt;
    logic [7:0] pend_r;
    logic [7:0] pend_nxt;
    logic pend_posted_r;
    logic pend_posted_nxt;
    logic pend_norec_r;
    logic pend_norec_nxt;
    logic [7:0] report_r;
    logic [7:0] report_nxt;
    logic posted_r;
    logic posted_nxt;
    logic norec_r;
    logic norec_nxt;
    logic wake_r;
    logic wake_nxt;
    logic [7:0] pick;
    logic fully_on;

    assign link.report = report_r;
    assign link.posted = posted_r;
    assign link.no_recovery = norec_r;
    assign link.wake_request_in = wake_r;
    assign o_ready = state_r == uerp_pkg::UERP_ST_IDLE;
    assign o_waiting = state_r == uerp_pkg::UERP_ST_WAIT;
    assign o_sent = report_r != uerp_pkg::REP_NONE;
    // Only one error is reported per packet, so the lowest set bit is kept.
    assign pick = i_err_found & (~i_err_found + 8'h01);
    assign fully_on = link.power_state_bits == uerp_pkg::PWR_FULLY_ON;

    always_comb
    begin
        state_nxt = state_r;
        pend_nxt = pend_r;
        pend_posted_nxt = pend_posted_r;
        pend_norec_nxt = pend_norec_r;
        report_nxt = uerp_pkg::REP_NONE;
        posted_nxt = posted_r;
        norec_nxt = norec_r;
        wake_nxt = 1'b0;
        unique case (state_r)
            uerp_pkg::UERP_ST_IDLE:
            begin
                if (i_err_valid && pick != uerp_pkg::REP_NONE)
                begin
                    if (fully_on)
                    begin
                        report_nxt = pick;
                        posted_nxt = i_posted;
                        norec_nxt = i_no_recovery;
                    end
                    else
                    begin
                        pend_nxt = pick;
                        pend_posted_nxt = i_posted;
                        pend_norec_nxt = i_no_recovery;
                        wake_nxt = link.wake_event_enable;
                        state_nxt = uerp_pkg::UERP_ST_WAIT;
                    end
                end
            end
            uerp_pkg::UERP_ST_WAIT:
            begin
                if (fully_on)
                begin
                    report_nxt = pend_r;
                    posted_nxt = pend_posted_r;
                    norec_nxt = pend_norec_r;
                    state_nxt = uerp_pkg::UERP_ST_IDLE;
                end
            end
            default:
            begin
                state_nxt = uerp_pkg::UERP_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            state_r <= uerp_pkg::UERP_ST_IDLE;
            pend_r <= uerp_pkg::REP_NONE;
            pend_posted_r <= 1'b0;
            pend_norec_r <= 1'b0;
            report_r <= uerp_pkg::REP_NONE;
            posted_r <= 1'b0;
            norec_r <= 1'b0;
            wake_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            pend_r <= pend_nxt;
            pend_posted_r <= pend_posted_nxt;
            pend_norec_r <= pend_norec_nxt;
            report_r <= report_nxt;
            posted_r <= posted_nxt;
            norec_r <= norec_nxt;
            wake_r <= wake_nxt;
        end
    end
endmodule : uerp_user_end

// ---- user_error_report_port_tb.sv ----
module user_error_report_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_sys_clk, i_reset_n, wake_en, adv_on, valid, posted, no_rec;
    logic send_cpl, cpl_st, send_msg, wake_req, misuse, waiting, ready, sent;
    int sent_cnt = 0;
    logic [1:0] pwr, kind;
    logic [7:0] sev, found;
    logic [2:0] msg_en;
    logic [4:0] exp_q[$];
    int bad_count = 0;
    int cmp_count = 0;
    int seed = 54292;
    int wake_cnt = 0;
    uerp_if link ();
    uerp_core_end u_uerp_core_end (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .link(link),
        .i_power_state(pwr), .i_wake_event_enable(wake_en),
        .i_advanced_error_reporting_enable(adv_on),
        .i_fatal_severity(sev), .i_msg_enable(msg_en), .o_send_cpl(send_cpl),
        .o_cpl_status(cpl_st), .o_send_msg(send_msg), .o_msg_kind(kind),
        .o_wake_req(wake_req), .o_misuse(misuse));
    uerp_user_end u_uerp_user_end (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .link(link),
        .i_err_valid(valid), .i_err_found(found), .i_posted(posted), .i_no_recovery(no_rec),
        .o_ready(ready), .o_waiting(waiting), .o_sent(sent));
    uerp_checker u_uerp_checker (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
        .report(link.report), .posted(link.posted), .power_state_bits(link.power_state_bits),
        .wake_event_enable(link.wake_event_enable), .wake_request_in(link.wake_request_in),
        .i_advanced_error_reporting_enable(adv_on), .i_msg_enable(msg_en), .o_send_cpl(send_cpl),
        .o_cpl_status(cpl_st), .o_send_msg(send_msg), .o_msg_kind(kind), .o_wake_req(wake_req));
    task check(input logic [4:0] seen, input logic [4:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    // Expected {cpl, status, msg, kind}; status and kind are masked when not sent.
    function logic [4:0] expect_of(int k, logic p, logic nr);
        logic [1:0] sv, kd;
        logic adv, en;
        sv = (adv_on && sev[k]) ? 2'h2 : 2'h1;
        adv = (k == 0 && !p) || k == 3 || k == 4 || (k == 2 && !nr);
        kd = (adv || k > 5 || (k == 1 && !p && adv_on)) ? 2'h0 : ((k == 1 && !p) ? 2'h1 : sv);
        en = (!adv || adv_on || k > 5) && msg_en[kd];
        return {(k == 0 && !p) || k == 1, k == 1, en, en ? kd : 2'h0};
    endfunction : expect_of
    // Lower bits of the error set are kept clear so the chosen kind is the lowest one.
    task req(input int k, input logic p, input logic nr);
        valid = 1'b1;
        found = (8'($random(seed)) | 8'h01) << k;
        posted = p;
        no_rec = nr;
        exp_q.push_back(expect_of(k, p, nr));
        @(negedge i_sys_clk);
    endtask : req
    task idle(input int n);
        valid = 1'b0;
        repeat (n) @(negedge i_sys_clk);
    endtask : idle
    initial
    begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    initial
    begin
        logic pend;
        pend = 1'b0;
        forever
        begin
            @(negedge i_sys_clk);
            if (pend)
                check({send_cpl, send_cpl & cpl_st, send_msg, send_msg ? kind : 2'h0},
                    exp_q.pop_front());
            pend = link.report != 8'h00;
            wake_cnt += int'(wake_req === 1'b1);
            sent_cnt += int'(sent === 1'b1);
            check({4'h0, misuse}, 5'h00);
        end
    end
    initial
    begin
        #20000;
        bad_count++;
        print_verdict();
    end
    initial
    begin
        {i_reset_n, pwr, wake_en, adv_on, sev, msg_en, valid, found, posted, no_rec} = '0;
        repeat (12) @(negedge i_sys_clk);
        i_reset_n = 1'b1;
        for (int i = 0; i < 64; i++)
        begin
            adv_on = i[5];
            sev = 8'($random(seed));
            msg_en = 3'($random(seed));
            req(i % 8, i[3], i[4]);
            idle(3);
        end
        msg_en = 3'h7;
        for (int i = 0; i < 8; i++)
            req(i, 1'b1, 1'b1);
        idle(3);
        for (int w = 0; w < 2; w++)
        begin
            pwr = 2'h3;
            wake_en = w[0];
            wake_cnt = 0;
            idle(2);
            req(6, 1'b0, 1'b0);
            idle(1);
            check({3'h0, ready, waiting}, 5'h01);
            valid = 1'b1;
            @(negedge i_sys_clk);
            idle(5);
            check(5'(exp_q.size()), 5'h01);
            check(5'(wake_cnt), 5'(w));
            pwr = 2'h0;
            idle(5);
        end
        check(5'(exp_q.size()), 5'h00);
        check(5'(sent_cnt - 74), 5'h00);
        print_verdict();
    end
endmodule : user_error_report_port_tb
